// ==== hw/adcsq_pkg.sv ====
// constants, register map and carrier types of the conversion sequencing control
`default_nettype none
package adcsq_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [7:0] IDX_RES_LOW  = 8'h20;
    localparam logic [7:0] IDX_RES_HIGH = 8'h21;
    localparam logic [7:0] IDX_CONTROL  = 8'h22;
    localparam logic [7:0] IDX_CLK_SEL  = 8'h23;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h24;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h25;
    localparam int         ADDR_SHIFT   = 2;

    // control byte fields
    localparam int CTL_START_BIT = 7;
    localparam int CTL_EOC_BIT   = 6;
    localparam int CTL_PCFG_LSB  = 3;
    localparam int CTL_CHAN_LSB  = 0;

    // clock select byte fields
    localparam int         CSEL_TEST_BIT = 7;
    localparam logic [1:0] CSEL_DIV2     = 2'h0;
    localparam logic [1:0] CSEL_DIV8     = 2'h1;
    localparam logic [1:0] CSEL_DIV32    = 2'h2;

    // conversion clock divisors, as terminal counts
    localparam logic [4:0] DIV2_LAST  = 5'h01;
    localparam logic [4:0] DIV8_LAST  = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1F;

    // conversion length in conversion clock periods
    localparam int CONV_PERIODS = 76;
    localparam int RES_BITS     = 9;

    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [1:0] CLKSEL_RST  = 2'h0;
    localparam logic       EOC_N_RST   = 1'b1;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ADCSQ_IDLE  = 3'b001,
        ADCSQ_ARMED = 3'b010,
        ADCSQ_CONV  = 3'b100
    } adcsq_state_t;

    // quantised codes from the analog front end, one per input
    typedef struct packed {
        logic [8:0] in3;
        logic [8:0] in2;
        logic [8:0] in1;
        logic [8:0] in0;
    } adcsq_samples_t;
endpackage : adcsq_pkg
`default_nettype wire

// ==== hw/adcsq_top.sv ====
// sequencing control of the four-input conversion unit with APB register access
// Summary of operation
// - result low and high bytes are read-only and writes to them are ignored.
// - a rising start bit resets the converter and sets the done flag (active low) to 1.
// - completion clears the done flag and interrupts only when that source is enabled.
// - completion sets the converter interrupt request flag.
// - the done flag reads in control bit 6, with 0 meaning the conversion has ended.
// - control bits 2..0 pick input 0..3; codes with bit 2 set are not to be used.
// - control bits 5..3 set how many port-B lines are analog; 000 powers the unit off.
// - each analog line loses digital I/O and pull-high, and any analog line powers up.
// - clock-select bits 1..0 give system clock divided by 2, 8 or 32.
// - clock-select bits 6..2 read as 0 and bit 7 is a test bit.
// - result bit 0 sits in low-byte bit 7 and bits 8..1 fill the high byte.
// - a conversion lasts 76 conversion clock periods.
`default_nettype none
module adcsq_top #(
    parameter int CONV_LEN = adcsq_pkg::CONV_PERIODS
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire adcsq_pkg::adcsq_samples_t samples,
    output logic [3:0]                    port_b_analog,
    output logic                          conv_power_on,
    output logic [1:0]                    conv_channel,
    output logic                          irq
);
    // lengths beyond the 7-bit period counter cannot be served
    if (CONV_LEN < 2 || CONV_LEN > 127) begin : g_len_check
        $error("CONV_LEN out of range");
    end

    localparam logic [6:0] CONV_LAST = 7'(CONV_LEN - 1);

    // reset release through two flops
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    function automatic logic [3:0] pcfg_mask(input logic [2:0] cfg);
        logic [3:0] m;
        m = 4'h0;
        unique case (cfg)
            3'h0:    m = 4'h0;
            3'h1:    m = 4'h1;
            3'h2:    m = 4'h3;
            3'h3:    m = 4'h7;
            default: m = 4'hF;
        endcase
        return m;
    endfunction : pcfg_mask

    // registers
    logic [7:0]             ctrl_r;
    logic                   eoc_n_r;
    logic [1:0]             clksel_r;
    logic                   test_r;
    logic [8:0]             result_r;
    logic                   irq_stat_r;
    logic                   irq_mask_r;
    logic [31:0]            prdata_r;
    adcsq_pkg::adcsq_state_t state_r;
    adcsq_pkg::adcsq_state_t state_nxt;
    logic [1:0]             chan_r;
    logic [4:0]             div_r;
    logic [6:0]             tad_cnt_r;

    // bus decode
    wire       setup    = psel & ~penable;
    wire       wr_acc   = psel & penable & pwrite & pstrb[0];
    wire [7:0] idx      = paddr >> adcsq_pkg::ADDR_SHIFT;
    wire       aligned  = (paddr[1:0] == 2'h0);
    wire       sel_rl   = aligned & (idx == adcsq_pkg::IDX_RES_LOW);
    wire       sel_rh   = aligned & (idx == adcsq_pkg::IDX_RES_HIGH);
    wire       sel_ctl  = aligned & (idx == adcsq_pkg::IDX_CONTROL);
    wire       sel_csel = aligned & (idx == adcsq_pkg::IDX_CLK_SEL);
    wire       sel_stat = aligned & (idx == adcsq_pkg::IDX_IRQ_STAT);
    wire       sel_mask = aligned & (idx == adcsq_pkg::IDX_IRQ_MASK);
    wire       mapped   = sel_rl | sel_rh | sel_ctl | sel_csel | sel_stat | sel_mask;
    wire       wr_ctl   = wr_acc & sel_ctl;
    wire       wr_csel  = wr_acc & sel_csel;
    wire       wr_stat  = wr_acc & sel_stat;
    wire       wr_mask  = wr_acc & sel_mask;

    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_r;

    // start edges seen through software writes
    wire start_old  = ctrl_r[adcsq_pkg::CTL_START_BIT];
    wire start_rise = wr_ctl & pwdata[adcsq_pkg::CTL_START_BIT] & ~start_old;
    wire start_fall = wr_ctl & ~pwdata[adcsq_pkg::CTL_START_BIT] & start_old;

    // conversion clock enable
    wire [4:0] div_last = (clksel_r == adcsq_pkg::CSEL_DIV2) ? adcsq_pkg::DIV2_LAST :
                          (clksel_r == adcsq_pkg::CSEL_DIV8) ? adcsq_pkg::DIV8_LAST :
                                                               adcsq_pkg::DIV32_LAST;
    wire       tad_en   = (state_r == adcsq_pkg::ADCSQ_CONV) & (div_r == div_last);
    wire       conv_done = tad_en & (tad_cnt_r == CONV_LAST);

    // watch counter for the conversion length; a clock-select write in mid-run
    // stretches or cuts short the running period, so such a run is left out of the length check
    logic [11:0] conv_cyc_r;
    logic        csel_moved_r;
    wire  [11:0] conv_cyc_exp = 12'(CONV_LEN * (int'(div_last) + 1) - 1);
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            conv_cyc_r   <= 12'h000;
            csel_moved_r <= 1'b0;
        end else if (state_r != adcsq_pkg::ADCSQ_CONV || start_rise) begin
            conv_cyc_r   <= 12'h000;
            csel_moved_r <= 1'b0;
        end else begin
            conv_cyc_r   <= conv_cyc_r + 12'h001;
            csel_moved_r <= csel_moved_r | wr_csel;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            adcsq_pkg::ADCSQ_IDLE:  if (start_rise) state_nxt = adcsq_pkg::ADCSQ_ARMED;
            adcsq_pkg::ADCSQ_ARMED: if (start_fall) state_nxt = adcsq_pkg::ADCSQ_CONV;
            adcsq_pkg::ADCSQ_CONV: begin
                if (start_rise) begin
                    state_nxt = adcsq_pkg::ADCSQ_ARMED;
                end else if (conv_done) begin
                    state_nxt = adcsq_pkg::ADCSQ_IDLE;
                end
            end
            default: state_nxt = adcsq_pkg::ADCSQ_IDLE;
        endcase
    end

    wire [1:0] chan_sel = ctrl_r[adcsq_pkg::CTL_CHAN_LSB +: 2];
    wire [8:0] sample_pick = (chan_r == 2'h0) ? samples.in0 :
                             (chan_r == 2'h1) ? samples.in1 :
                             (chan_r == 2'h2) ? samples.in2 : samples.in3;

    wire [3:0] analog_mask = pcfg_mask(ctrl_r[adcsq_pkg::CTL_PCFG_LSB +: 3]);

    // read mux; result alignment, unused bits zero, done flag position
    wire [7:0] rd_byte = sel_rl   ? {result_r[0], 7'h00} :
                         sel_rh   ? result_r[8:1] :
                         sel_ctl  ? {ctrl_r[7], eoc_n_r, ctrl_r[5:0]} :
                         sel_csel ? {test_r, 5'h00, clksel_r} :
                         sel_stat ? {7'h00, irq_stat_r} :
                         sel_mask ? {7'h00, irq_mask_r} : 8'h00;

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    // writes only reach the writable bytes; bit 6 of control is status only
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r     <= adcsq_pkg::CONTROL_RST;
            clksel_r   <= adcsq_pkg::CLKSEL_RST;
            test_r     <= 1'b0;
            irq_mask_r <= 1'b0;
        end else begin
            if (wr_ctl) ctrl_r <= {pwdata[7], 1'b0, pwdata[5:0]};
            if (wr_csel) clksel_r <= pwdata[1:0];
            if (wr_csel) test_r <= pwdata[adcsq_pkg::CSEL_TEST_BIT];
            if (wr_mask) irq_mask_r <= pwdata[0];
        end
    end

    // done flag: set on rising start, cleared on completion
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            eoc_n_r <= adcsq_pkg::EOC_N_RST;
        end else if (start_rise) begin
            eoc_n_r <= 1'b1;
        end else if (conv_done) begin
            eoc_n_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r   <= adcsq_pkg::ADCSQ_IDLE;
            div_r     <= 5'h00;
            tad_cnt_r <= 7'h00;
            chan_r    <= 2'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r != adcsq_pkg::ADCSQ_CONV || start_rise || tad_en) begin
                div_r <= 5'h00;
            end else begin
                div_r <= div_r + 5'h01;
            end
            if (state_r != adcsq_pkg::ADCSQ_CONV || start_rise) begin
                tad_cnt_r <= 7'h00;
            end else if (tad_en) begin
                tad_cnt_r <= tad_cnt_r + 7'h01;
            end
            if (state_r == adcsq_pkg::ADCSQ_ARMED && start_fall) chan_r <= chan_sel;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            result_r <= 9'h000;
        end else if (conv_done && !start_rise) begin
            result_r <= sample_pick;
        end
    end

    // sticky request, write one to clear, a new event wins
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_stat_r <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_stat & pwdata[0])) | (conv_done & ~start_rise);
        end
    end

    assign irq = irq_stat_r & irq_mask_r;
    // analog lines drop digital I/O and pull-high; any analog line powers up
    assign port_b_analog = analog_mask;
    assign conv_power_on = |analog_mask;
    assign conv_channel  = chan_r;

    // checks
    ro_write_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (wr_acc & (sel_rl | sel_rh) & ~conv_done) |=> $stable(result_r))
        else $error("result changed by a write");
    start_set_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        start_rise |=> (eoc_n_r && state_r == adcsq_pkg::ADCSQ_ARMED))
        else $error("rising start did not arm and set flag");
    done_flag_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (conv_done & ~start_rise) |=> (!eoc_n_r && state_r == adcsq_pkg::ADCSQ_IDLE))
        else $error("done flag not cleared at completion");
    irq_set_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (conv_done & ~start_rise) |=> irq_stat_r)
        else $error("request flag not set");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        irq == (irq_stat_r && irq_mask_r))
        else $error("interrupt output not gated by enable");
    chan_pick_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (conv_done & ~start_rise) |=> result_r == $past(sample_pick))
        else $error("result not from selected input");
    power_off_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (ctrl_r[5:3] == 3'h0) |-> (!conv_power_on && port_b_analog == 4'h0))
        else $error("unit powered with all lines digital");
    div2_rate_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (state_r == adcsq_pkg::ADCSQ_CONV && $past(state_r) == adcsq_pkg::ADCSQ_CONV &&
         clksel_r == adcsq_pkg::CSEL_DIV2 && !csel_moved_r) |-> tad_en != $past(tad_en))
        else $error("divide-by-2 clock wrong");
    csel_zero_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (setup & ~pwrite & sel_csel) |=> prdata_r[6:2] == 5'h00)
        else $error("unused clock-select bits not zero");
    low_align_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (setup & ~pwrite & sel_rl) |=>
            (prdata_r[6:0] == 7'h00 && prdata_r[7] == $past(result_r[0])))
        else $error("low result byte misaligned");
    conv_len_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (conv_done && !csel_moved_r) |-> conv_cyc_r == conv_cyc_exp)
        else $error("conversion length wrong");
    abort_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (state_r == adcsq_pkg::ADCSQ_CONV && start_rise) |=> (tad_cnt_r == 7'h00 && eoc_n_r))
        else $error("restart did not abort");
    high_align_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (setup & ~pwrite & sel_rh) |=> prdata_r[7:0] == $past(result_r[8:1]))
        else $error("high result byte misaligned");
    irq_clear_a: assert property (@(posedge clk) disable iff (!rst_n_r)
        (wr_stat && pwdata[0] && !conv_done) |=> !irq_stat_r)
        else $error("request flag not cleared by write");
endmodule : adcsq_top
`default_nettype wire

// ==== hw/adcsq_unused_placeholder_none.sv ====
// intentionally no further logic; sequencing control lives in adcsq_top
`default_nettype none
`default_nettype wire

// ==== testbench/adcsq_testbench.sv ====
// self-checking testbench of the conversion sequencing control, driven over APB
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // shortened conversion length keeps the run brief
    localparam int         LEN    = 5;
    localparam logic [7:0] A_LOW  = adcsq_pkg::IDX_RES_LOW << adcsq_pkg::ADDR_SHIFT;
    localparam logic [7:0] A_HIGH = adcsq_pkg::IDX_RES_HIGH << adcsq_pkg::ADDR_SHIFT;
    localparam logic [7:0] A_CTL  = adcsq_pkg::IDX_CONTROL << adcsq_pkg::ADDR_SHIFT;
    localparam logic [7:0] A_CSEL = adcsq_pkg::IDX_CLK_SEL << adcsq_pkg::ADDR_SHIFT;
    localparam logic [7:0] A_STAT = adcsq_pkg::IDX_IRQ_STAT << adcsq_pkg::ADDR_SHIFT;
    localparam logic [7:0] A_MASK = adcsq_pkg::IDX_IRQ_MASK << adcsq_pkg::ADDR_SHIFT;

    logic                      clk     = 1'b0;
    logic                      rstn    = 1'b0;
    logic                      psel    = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite  = 1'b0;
    logic [7:0]                paddr   = 8'h00;
    logic [31:0]               pwdata  = 32'h0;
    logic [3:0]                pstrb   = 4'hF;
    adcsq_pkg::adcsq_samples_t samples = {9'h0FF, 9'h155, 9'h0B3, 9'h1A5};
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [3:0]                port_b_analog;
    logic                      conv_power_on;
    logic [1:0]                conv_channel;
    logic                      irq;
    int                        fail_count = 0;
    int                        checks     = 0;
    int                        cycles     = 0;
    logic [31:0]               rd;
    logic                      err;

    always #10 clk = ~clk;

    adcsq_top #(.CONV_LEN(LEN)) DUT (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .samples(samples), .port_b_analog(port_b_analog),
        .conv_power_on(conv_power_on), .conv_channel(conv_channel), .irq(irq)
    );

    task automatic summarize();
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one transfer; an idle cycle follows so no signal is driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // counts edges from the write edge until the interrupt line rises
    task automatic wait_irq(input int exp);
        int k;
        k = 1;
        while (k < 3000) begin
            @(negedge clk);
            if (irq === 1'b1) break;
            k++;
        end
        chk(32'(k), 32'(exp));
        @(posedge clk);
    endtask : wait_irq

    task automatic t_reset();
        rdchk(A_CTL, 32'h40);
        rdchk(A_CSEL, 32'h0);
        rdchk(A_LOW, 32'h0);
        rdchk(A_HIGH, 32'h0);
        rdchk(A_STAT, 32'h0);
        rdchk(A_MASK, 32'h0);
    endtask : t_reset

    task automatic t_access();
        apb(1'b1, A_LOW, 32'hFF);
        apb(1'b1, A_HIGH, 32'hFF);
        rdchk(A_LOW, 32'h0);
        rdchk(A_HIGH, 32'h0);
        apb(1'b1, A_CSEL, 32'hFE);
        rdchk(A_CSEL, 32'h82);
        pstrb <= 4'h0;
        apb(1'b1, A_CSEL, 32'h01);
        pstrb <= 4'hF;
        rdchk(A_CSEL, 32'h82);
        apb(1'b0, 8'hFC, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, A_CSEL, 32'h0);
    endtask : t_access

    task automatic t_ports();
        logic [3:0] pb_exp [8] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hF, 4'hF, 4'hF};
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, A_CTL, 32'(c) << 3);
            chk(32'(port_b_analog), 32'(pb_exp[c]));
            chk(32'(conv_power_on), 32'(c != 0));
        end
    endtask : t_ports

    task automatic t_conv();
        logic [1:0] code [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        int         div [4]  = '{2, 8, 32, 2};
        int         ch;
        logic [8:0] s;
        apb(1'b1, A_MASK, 32'h1);
        for (int i = 0; i < 4; i++) begin
            ch = (i + 1) % 4;
            s  = samples[9 * ch +: 9];
            apb(1'b1, A_CSEL, 32'(code[i]));
            apb(1'b1, A_CTL, 32'hA0 | 32'(ch));
            rdchk(A_CTL, 32'hE0 | 32'(ch));
            chk(rd & 32'h40, 32'h40);
            // start stays low until the flag drops
            apb(1'b1, A_CTL, 32'h20 | 32'(ch));
            wait_irq(LEN * div[i]);
            rdchk(A_CTL, 32'h20 | 32'(ch));
            chk(32'(conv_channel), 32'(ch));
            rdchk(A_HIGH, 32'(s[8:1]));
            rdchk(A_LOW, 32'({s[0], 7'h0}));
            rdchk(A_STAT, 32'h1);
            apb(1'b1, A_STAT, 32'h1);
            chk(32'(irq), 32'h0);
        end
    endtask : t_conv

    task automatic t_abort();
        apb(1'b1, A_MASK, 32'h0);
        apb(1'b1, A_CTL, 32'hA1);
        apb(1'b1, A_CTL, 32'h21);
        repeat (LEN) @(posedge clk);
        apb(1'b1, A_CTL, 32'hA2);
        rdchk(A_CTL, 32'hE2);
        chk(rd & 32'h40, 32'h40);
        repeat (4 * LEN) @(posedge clk);
        rdchk(A_STAT, 32'h0);
        rdchk(A_HIGH, 32'(samples.in0[8:1]));
        apb(1'b1, A_CTL, 32'h22);
        repeat (2 * LEN + 4) @(posedge clk);
        rdchk(A_STAT, 32'h1);
        chk(32'(irq), 32'h0);
        apb(1'b1, A_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        rdchk(A_HIGH, 32'(samples.in2[8:1]));
        apb(1'b1, A_STAT, 32'h1);
        chk(32'(irq), 32'h0);
    endtask : t_abort

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_access();
        t_ports();
        t_conv();
        t_abort();
        summarize();
    end
endmodule : testbench
`default_nettype wire
